//--- crtw_pkg.sv
package crtw_pkg;
  localparam int unsigned CRTW_ADDR_W = 13;
  localparam logic [12:0] CRTW_OFF_CTRL_STATUS = 13'h0008;
  localparam logic [12:0] CRTW_OFF_COUNT_VALUE = 13'h0009;
  localparam logic [12:0] CRTW_OFF_WDOG_CLEAR = 13'h1FF0;
  localparam int unsigned CRTW_POS_WRAP_FLAG = 7;
  localparam int unsigned CRTW_POS_PER_FLAG = 6;
  localparam int unsigned CRTW_POS_WRAP_IE = 5;
  localparam int unsigned CRTW_POS_PER_IE = 4;
  localparam int unsigned CRTW_POS_WRAP_CLR = 3;
  localparam int unsigned CRTW_POS_PER_CLR = 2;
  localparam int unsigned CRTW_POS_RATE_HI = 1;
  localparam int unsigned CRTW_POS_RATE_LO = 0;
  localparam int unsigned CRTW_POS_WDOG_CLR = 0;
  localparam logic [1:0] CRTW_RATE_RESET = 2'h3;
  localparam int unsigned CRTW_PRESCALE = 4;
  localparam int unsigned CRTW_CHAIN_W = 22;
  localparam int unsigned CRTW_POR_RELEASE_COUNT = 4064;
  localparam int unsigned CRTW_INT_RESET_CYCLES = 4;
  typedef struct packed {
    logic wrap_flag;
    logic periodic_flag;
    logic wrap_irq_enable;
    logic periodic_irq_enable;
    logic [1:0] rate_select;
  } crtw_ctrl_t;
endpackage : crtw_pkg

//--- crtw_core_timer.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Function
// [RULE1] counter clocked by bus clock over four
// [RULE2] count register read-only, returns present count
// [RULE3] wrap flag set on all-ones to zero
// [RULE4] wrap interrupt while flag and enable set
// [RULE5] writing bit 3 clears wrap flag
// [RULE6] wrap enable gates requests, reset clears
// [RULE7] wrap every 1024 bus cycles
// [RULE8] four more stages give divide by 16384
// [RULE9] three stages plus one-of-four tap selector
// [RULE10] watchdog counts selected periodic output by eight
// [RULE11] timeout between seven and eight periods
// [RULE12] timeout issues internal reset
// [RULE13] software writes zero to clear watchdog
// [RULE14] clear resets only divide-by-eight stage
// [RULE15] watchdog enable is a fixed option
// [RULE16] power-on clears chain, releases after 4064
// [RULE17] after release chain counts from zero
// [RULE18] external reset clears whole chain
// [RULE19] periodic flag set on tap, cleared by write
// [RULE20] rate codes select 2^14 to 2^17, reset ones
// [RULE21] stop entry and exit clear the chain
// [RULE22] count read has no side effects
module crtw_core_timer
  import crtw_pkg::*;
#(
  parameter bit WDOG_ENABLE = 1'b1,
  parameter int unsigned POR_COUNT = CRTW_POR_RELEASE_COUNT
)(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic ext_reset_in,
  input wire logic stop_in,
  input wire logic [12:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [7:0] avs_writedata_in,
  output logic [7:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic wrap_irq_out,
  output logic periodic_irq_out,
  output logic internal_reset_out,
  output logic por_active_out
);
  logic [2:0] ext_sync;
  logic [2:0] stop_sync;
  logic ext_level;
  logic stop_level;
  logic [CRTW_CHAIN_W-1:0] chain;
  logic [12:0] por_cnt;
  logic por_busy;
  logic [1:0] rate_select;
  logic wrap_flag;
  logic periodic_flag;
  logic wrap_irq_enable;
  logic periodic_irq_enable;
  logic [2:0] wdog_div;
  logic [1:0] wdog_hold;
  logic ack;
  logic chain_clear;
  logic [CRTW_CHAIN_W-1:0] next_chain;
  logic wrap_event;
  logic tap_event;
  logic wdog_timeout;
  logic wr_ctrl;
  logic wr_wdog;
  crtw_ctrl_t status;

  function automatic logic tap_edge(input logic [CRTW_CHAIN_W-1:0] a,
                                    input logic [CRTW_CHAIN_W-1:0] b,
                                    input logic [1:0] sel);
    logic [4:0] idx;
    idx = 5'(13 + 32'(sel));
    tap_edge = a[idx] & ~b[idx];
  endfunction : tap_edge

  // pin synchronisers
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ext_sync <= 3'h0;
      stop_sync <= 3'h0;
      ext_level <= 1'b0;
      stop_level <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_reset_in};
      stop_sync <= {stop_sync[1:0], stop_in};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
      if (stop_sync[1] == stop_sync[2])
        stop_level <= stop_sync[2];
    end
  end

  // power-on release counter
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      por_cnt <= 13'h0000;
      por_busy <= 1'b1;
    end
    else if (por_busy)
    begin
      if (32'(por_cnt) >= POR_COUNT - 1)
        por_busy <= 1'b0; // [RULE16]
      else
        por_cnt <= por_cnt + 13'h0001;
    end
  end

  assign chain_clear = (por_busy && 32'(por_cnt) >= POR_COUNT - 1)
                       || ext_level || stop_level; // [RULE16] [RULE18] [RULE21]
  // bits 1:0 prescale, 9:2 ripple count, 13:10 four stages, 16:14 rate stages
  assign next_chain = chain + 22'h000001; // [RULE1] [RULE8] [RULE9]
  assign wrap_event = &chain[9:0]; // [RULE3] [RULE7]
  assign tap_event = tap_edge(next_chain, chain, rate_select) && !chain_clear; // [RULE20]
  assign wr_ctrl = avs_write_in && !ack && avs_address_in == CRTW_OFF_CTRL_STATUS;
  assign wr_wdog = avs_write_in && !ack && avs_address_in == CRTW_OFF_WDOG_CLEAR;
  assign wdog_timeout = WDOG_ENABLE && !por_busy && tap_event
                        && wdog_div == 3'h7; // [RULE10] [RULE11] [RULE15]

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      chain <= 22'h000000;
    else if (chain_clear || internal_reset_out)
      chain <= 22'h000000; // [RULE17] [RULE18]
    else
      chain <= next_chain;
  end

  // control bits
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rate_select <= CRTW_RATE_RESET; // [RULE20]
      wrap_irq_enable <= 1'b0; // [RULE6]
      periodic_irq_enable <= 1'b0;
    end
    else if (internal_reset_out || ext_level)
    begin
      rate_select <= CRTW_RATE_RESET;
      wrap_irq_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      rate_select <= avs_writedata_in[CRTW_POS_RATE_HI:CRTW_POS_RATE_LO];
      wrap_irq_enable <= avs_writedata_in[CRTW_POS_WRAP_IE];
      periodic_irq_enable <= avs_writedata_in[CRTW_POS_PER_IE];
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wrap_flag <= 1'b0;
      periodic_flag <= 1'b0;
    end
    else if (internal_reset_out || ext_level)
    begin
      wrap_flag <= 1'b0; // [RULE5]
      periodic_flag <= 1'b0;
    end
    else
    begin
      if (wrap_event && !chain_clear)
        wrap_flag <= 1'b1; // [RULE3]
      else if (wr_ctrl && avs_writedata_in[CRTW_POS_WRAP_CLR])
        wrap_flag <= 1'b0; // [RULE5]
      if (tap_event)
        periodic_flag <= 1'b1; // [RULE19]
      else if (wr_ctrl && avs_writedata_in[CRTW_POS_PER_CLR])
        periodic_flag <= 1'b0; // [RULE19]
    end
  end

  // watchdog divide-by-eight and internal reset pulse
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wdog_div <= 3'h0;
      wdog_hold <= 2'h0;
      internal_reset_out <= 1'b0;
    end
    else
    begin
      if (wdog_timeout)
      begin
        wdog_hold <= 2'(CRTW_INT_RESET_CYCLES - 1);
        internal_reset_out <= 1'b1; // [RULE12]
      end
      else if (wdog_hold != 2'h0)
        wdog_hold <= wdog_hold - 2'h1;
      else
        internal_reset_out <= 1'b0;
      if (chain_clear || internal_reset_out
          || (wr_wdog && !avs_writedata_in[CRTW_POS_WDOG_CLR]))
        wdog_div <= 3'h0; // [RULE13] [RULE14]
      else if (tap_event)
        wdog_div <= wdog_div + 3'h1; // [RULE10]
    end
  end

  assign status = '{wrap_flag, periodic_flag, wrap_irq_enable,
                    periodic_irq_enable, rate_select};

  // avalon slave: one wait cycle per access
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ack <= 1'b0;
      avs_readdata_out <= 8'h00;
    end
    else
    begin
      ack <= (avs_read_in || avs_write_in) && !ack;
      if (avs_read_in && !ack)
      begin
        case (avs_address_in)
          CRTW_OFF_CTRL_STATUS: avs_readdata_out <= {status[5:2], 2'h0, status[1:0]};
          CRTW_OFF_COUNT_VALUE: avs_readdata_out <= chain[9:2]; // [RULE2] [RULE22]
          default: avs_readdata_out <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wrap_irq_out <= 1'b0;
      periodic_irq_out <= 1'b0;
      por_active_out <= 1'b1;
    end
    else
    begin
      wrap_irq_out <= wrap_flag && wrap_irq_enable; // [RULE4] [RULE6]
      periodic_irq_out <= periodic_flag && periodic_irq_enable; // [RULE19]
      por_active_out <= por_busy;
    end
  end
endmodule : crtw_core_timer
`default_nettype wire

//--- crtw_checker.sv
`timescale 1ns/10ps
`default_nettype none
module crtw_checker
  import crtw_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic ext_reset_in,
  input wire logic [12:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [7:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic wrap_irq_out,
  input wire logic periodic_irq_out,
  input wire logic internal_reset_out,
  input wire logic por_active_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  AST_WAIT_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
  AST_READ_ANSWER: assert property ($rose(avs_read_in) |=> !avs_waitrequest_out)
    else $error("read not answered in one cycle");
  AST_WRITE_ANSWER: assert property ($rose(avs_write_in) |=> !avs_waitrequest_out)
    else $error("write not answered in one cycle");
  AST_NO_SPURIOUS: assert property (!avs_waitrequest_out |-> $past(avs_read_in | avs_write_in))
    else $error("answer without request");
  AST_IE_OFF: assert property (avs_write_in && !avs_waitrequest_out &&
    avs_address_in == CRTW_OFF_CTRL_STATUS && !avs_writedata_in[CRTW_POS_WRAP_IE]
    |-> ##[0:2] !wrap_irq_out) else $error("wrap irq not gated off");
  AST_EXT_CLEAR: assert property (ext_reset_in [*8] |-> !wrap_irq_out && !periodic_irq_out)
    else $error("irq survives external reset");
  AST_POR_STAYS: assert property (!por_active_out |=> !por_active_out)
    else $error("power-on hold came back");
  AST_INT_PULSE: assert property ($rose(internal_reset_out) |->
    internal_reset_out [*4] ##1 !internal_reset_out) else $error("internal reset pulse length");
endmodule : crtw_checker
bind crtw_core_timer crtw_checker crtw_checker_inst (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ext_reset_in(ext_reset_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
  .wrap_irq_out(wrap_irq_out), .periodic_irq_out(periodic_irq_out),
  .internal_reset_out(internal_reset_out), .por_active_out(por_active_out)
);
`default_nettype wire

//--- crtw_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module crtw_cpu_model
  import crtw_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [7:0] avs_readdata_in,
  input wire logic avs_waitrequest_in,
  output var logic [12:0] avs_address_out,
  output var logic avs_read_out,
  output var logic avs_write_out,
  output var logic [7:0] avs_writedata_out
);
  initial
  begin
    avs_address_out = 13'h0000;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 8'h00;
  end
  // one bus access, held until the answer edge
  task access(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_in);
    avs_address_out <= a;
    avs_write_out <= w;
    avs_read_out <= !w;
    avs_writedata_out <= d;
    do @(posedge clk_sys_in);
    while (avs_waitrequest_in !== 1'b0);
    q = avs_readdata_in;
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
  endtask : access
  task wdog_kick(output logic [7:0] q);
    access(1'b1, CRTW_OFF_WDOG_CLEAR, 8'h00, q);
  endtask : wdog_kick
endmodule : crtw_cpu_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import crtw_pkg::*;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, ext_reset_in = 1'b0, stop_in = 1'b0;
  logic [12:0] adr;
  logic rd_s, wr_s, wt, wirq, pirq, irst, por;
  logic [7:0] wd, rdat, q, c0;
  int err_total = 0, total_checks = 0, i;
  initial forever #25 clk_sys_in = ~clk_sys_in;
  crtw_core_timer #(.POR_COUNT(16)) crtw_core_timer_inst (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .ext_reset_in(ext_reset_in), .stop_in(stop_in),
    .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .wrap_irq_out(wirq),
    .periodic_irq_out(pirq), .internal_reset_out(irst), .por_active_out(por));
  crtw_cpu_model crtw_cpu_model_inst (.clk_sys_in(clk_sys_in), .avs_readdata_in(rdat),
    .avs_waitrequest_in(wt), .avs_address_out(adr), .avs_read_out(rd_s),
    .avs_write_out(wr_s), .avs_writedata_out(wd));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [12:0] a);
    crtw_cpu_model_inst.access(1'b0, a, 8'h00, q);
  endtask : rd
  task wr(input logic [12:0] a, input logic [7:0] d);
    crtw_cpu_model_inst.access(1'b1, a, d, c0);
  endtask : wr
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 100 && por !== 1'b0; i++) @(posedge clk_sys_in);
    chk({7'h00, por}, 8'h00);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q, {6'h00, CRTW_RATE_RESET});
    rd(13'h0000);
    chk(q, 8'h00);
    $display("test reset done");
    rd(CRTW_OFF_COUNT_VALUE);
    c0 = q;
    repeat (41) @(posedge clk_sys_in);
    rd(CRTW_OFF_COUNT_VALUE);
    chk(q - c0, 8'h0B);
    $display("test count done");
    wr(CRTW_OFF_CTRL_STATUS, 8'h23);
    for (i = 0; i < 1100 && wirq !== 1'b1; i++) @(posedge clk_sys_in);
    chk({7'h00, wirq}, 8'h01);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q, 8'hA3);
    wr(CRTW_OFF_CTRL_STATUS, 8'h2B);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q, 8'h23);
    chk({7'h00, wirq}, 8'h00);
    wr(CRTW_OFF_CTRL_STATUS, 8'h03);
    repeat (1030) @(posedge clk_sys_in);
    chk({7'h00, wirq}, 8'h00);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q, 8'h83);
    for (i = 0; i < 4; i++)
    begin
      wr(CRTW_OFF_CTRL_STATUS, {6'h02, i[1:0]});
      rd(CRTW_OFF_CTRL_STATUS);
      chk(q & 8'h7F, {6'h00, i[1:0]});
    end
    crtw_cpu_model_inst.wdog_kick(c0);
    chk({7'h00, irst}, 8'h00);
    $display("test flags done");
    wr(CRTW_OFF_CTRL_STATUS, 8'h31);
    ext_reset_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    ext_reset_in <= 1'b0;
    rd(CRTW_OFF_COUNT_VALUE);
    chk({7'h00, q < 8'h05}, 8'h01);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q, {6'h00, CRTW_RATE_RESET});
    stop_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rd(CRTW_OFF_COUNT_VALUE);
    chk(q, 8'h00);
    repeat (20) @(posedge clk_sys_in);
    rd(CRTW_OFF_COUNT_VALUE);
    chk(q, 8'h00);
    stop_in <= 1'b0;
    $display("test reset paths done");
    wr(CRTW_OFF_CTRL_STATUS, 8'h10);
    for (i = 0; i < 17000 && pirq !== 1'b1; i++) @(posedge clk_sys_in);
    chk({7'h00, pirq}, 8'h01);
    chk({7'h00, i > 8150 && i < 8250}, 8'h01);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q & 8'h7F, 8'h50);
    wr(CRTW_OFF_CTRL_STATUS, 8'h14);
    rd(CRTW_OFF_CTRL_STATUS);
    chk(q & 8'h7F, 8'h10);
    $display("test periodic done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
